// ===== led_pwm_defs.vh
`ifndef LED_PWM_DEFS_VH
`define LED_PWM_DEFS_VH

// Register offsets
`define ADDR_PIN_LO 8'h00
`define ADDR_PIN_HI 8'h01
`define ADDR_MASTER_GLOBAL 8'h0E
`define ADDR_CONFIG 8'h0F
`define ADDR_INTENSITY_FIRST 8'h10
`define ADDR_INTENSITY_LAST 8'h17
`define ADDR_PIN_TOP 8'h20

// Field positions
`define CFG_GLOBAL_BIT 2
`define MASTER_MSB 7
`define MASTER_LSB 4
`define GLOBAL_MSB 3
`define GLOBAL_LSB 0
`define LAST_PORT_IDX 5'h10

// Reset values
`define RST_MASTER_GLOBAL 8'h00
`define RST_CONFIG 8'h00
`define RST_INTENSITY 8'hFF
`define RST_OE_N 17'h1FFFF
`define RST_RDATA 8'h00

// PWM structure
`define PWM_SLOTS 4'hF
`define PWM_CYCLES 5'h10
`define INTENSITY_STATIC 4'hF

// Timing: system clock and internal PWM oscillator rates
`define SYS_FREQ_HZ 25000000
`define OSC_FREQ_HZ 32000
`define OSC_DIV (`SYS_FREQ_HZ / `OSC_FREQ_HZ)

`endif

// ===== pwm_timebase.v
`timescale 1ns/10ps
`default_nettype none
`include "led_pwm_defs.vh"

module pwm_timebase (
    // Clock and reset
    input wire clk_sys,
    input wire rst_n,
    // Control
    input wire run,
    // Position within the PWM period
    output reg [3:0] cycle,
    output reg [3:0] slot,
    output reg step
);

    // Divider end point, cut to the prescaler width on purpose
    localparam integer DIV_FULL = `OSC_DIV - 1;
    localparam [9:0] DIV_LAST = DIV_FULL[9:0];

    reg [9:0] prescale;

    // Oscillator tick from system clock; held still while PWM is off
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prescale <= 10'h000;
            step <= 1'b0;
        end else if (!run) begin
            prescale <= 10'h000;
            step <= 1'b0;
        end else if (prescale == DIV_LAST) begin
            prescale <= 10'h000;
            step <= 1'b1;
        end else begin
            prescale <= prescale + 10'h001;
            step <= 1'b0;
        end
    end

    // 16 cycles per slot, 15 slots per period
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cycle <= 4'h0;
            slot <= 4'h0;
        end else if (!run) begin
            cycle <= 4'h0;
            slot <= 4'h0;
        end else if (step) begin
            cycle <= cycle + 4'h1;
            if (cycle == 4'hF) begin
                if (slot == `PWM_SLOTS - 4'h1) begin
                    slot <= 4'h0;
                end else begin
                    slot <= slot + 4'h1;
                end
            end
        end
    end

endmodule
`default_nettype wire

// ===== led_pwm_intensity_engine.v
`timescale 1ns/10ps
`default_nettype none
`include "led_pwm_defs.vh"

module led_pwm_intensity_engine (
    // Clock and reset
    input wire clk_sys,
    input wire rst_n,
    // Register access
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    // Blink phase levels and selection
    input wire [16:0] phase0_bits,
    input wire [16:0] phase1_bits,
    input wire blink_enable,
    input wire blink_phase,
    // Open-drain output pins
    input wire [16:0] port_in,
    output wire [16:0] port_out,
    output reg [16:0] port_oe_n,
    // Status
    output wire osc_running
);

    // Intensity and configuration storage
    reg [7:0] master_global_intensity;
    reg [7:0] config_reg;
    reg [7:0] output_intensity [0:7];
    reg [16:0] pin_s1;
    reg [16:0] pin_s2;
    reg [16:0] pin_s3;
    reg [16:0] pin_state;
    reg [16:0] next_oe_n;
    wire [3:0] cycle;
    wire [3:0] slot;
    wire [3:0] master;
    wire [3:0] global_nibble;
    wire global_sel;
    wire pwm_run;
    integer i;
    integer j;
    integer k;

    // Intensity code of one port: global nibble or its own field
    // Even ports use the low nibble of their pair, odd ports the high one
    // The last port always takes the global nibble
    function [3:0] port_code;
        input [4:0] idx;
        input glob;
        input [3:0] gnib;
        input [63:0] packed_regs;
        reg [2:0] r;
        begin
            r = idx[3:1];
            if (glob || idx == `LAST_PORT_IDX) begin
                port_code = gnib;
            end else if (idx[0]) begin
                port_code = packed_regs[r * 8 + 4 +: 4];
            end else begin
                port_code = packed_regs[r * 8 +: 4];
            end
        end
    endfunction

    // True for the eight per-port intensity offsets
    function in_intensity_range;
        input [7:0] addr;
        begin
            in_intensity_range = (addr >= `ADDR_INTENSITY_FIRST) &&
                                 (addr <= `ADDR_INTENSITY_LAST);
        end
    endfunction

    // Flatten the intensity array so one function call can pick any nibble
    reg [63:0] packed_regs;
    always @* begin
        packed_regs = 64'h0;
        for (i = 0; i < 8; i = i + 1) begin
            packed_regs[i * 8 +: 8] = output_intensity[i];
        end
    end

    assign master = master_global_intensity[`MASTER_MSB:`MASTER_LSB];
    assign global_nibble = master_global_intensity[`GLOBAL_MSB:`GLOBAL_LSB];
    assign global_sel = config_reg[`CFG_GLOBAL_BIT];
    // A master nibble of zero stops the timebase; every port is then static
    // and the divider stays still to keep the current low
    assign pwm_run = (master != 4'h0);
    assign osc_running = pwm_run;
    assign port_out = 17'h00000;

    // Timebase runs only while the master nibble is nonzero
    pwm_timebase u_timebase (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .run(pwm_run),
        .cycle(cycle),
        .slot(slot),
        .step()
    );

    // Register writes
    // Pin readback offsets are read-only, so writes there are dropped
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            master_global_intensity <= `RST_MASTER_GLOBAL;
            config_reg <= `RST_CONFIG;
            for (j = 0; j < 8; j = j + 1) begin
                output_intensity[j] <= `RST_INTENSITY;
            end
        end else if (reg_wr) begin
            if (reg_addr == `ADDR_MASTER_GLOBAL) begin
                master_global_intensity <= reg_wdata;
            end
            if (reg_addr == `ADDR_CONFIG) begin
                config_reg <= reg_wdata;
            end
            if (in_intensity_range(reg_addr)) begin
                output_intensity[reg_addr[2:0]] <= reg_wdata;
            end
        end
    end

    // Register reads, unmapped addresses return zero
    // Read data is registered and holds until the next read strobe
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= `RST_RDATA;
        end else if (reg_rd) begin
            if (reg_addr == `ADDR_MASTER_GLOBAL) begin
                reg_rdata <= master_global_intensity;
            end else if (reg_addr == `ADDR_CONFIG) begin
                reg_rdata <= config_reg;
            end else if (in_intensity_range(reg_addr)) begin
                reg_rdata <= output_intensity[reg_addr[2:0]];
            end else if (reg_addr == `ADDR_PIN_LO) begin
                reg_rdata <= pin_state[7:0];
            end else if (reg_addr == `ADDR_PIN_HI) begin
                reg_rdata <= pin_state[15:8];
            end else if (reg_addr == `ADDR_PIN_TOP) begin
                reg_rdata <= {7'h00, pin_state[16]};
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

    // Pin level readback, a high accepted when stages two and three agree, cleared to low when they differ
    // Stage one may be metastable, so only stage two reads it
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= 17'h00000;
            pin_s2 <= 17'h00000;
            pin_s3 <= 17'h00000;
            pin_state <= 17'h00000;
        end else begin
            pin_s1 <= port_in;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_state <= (pin_state & ~(pin_s2 ^ pin_s3)) | (pin_s2 & ~(pin_s2 ^ pin_s3));
        end
    end

    // Per-port level: on-time drives the phase bit, off-time its inverse
    reg [3:0] code;
    reg level;
    always @* begin
        next_oe_n = 17'h00000;
        code = 4'h0;
        level = 1'b0;
        for (k = 0; k < 17; k = k + 1) begin
            code = port_code(k[4:0], global_sel, global_nibble, packed_regs);
            if (blink_enable && blink_phase) begin
                level = phase1_bits[k];
            end else begin
                level = phase0_bits[k];
            end
            // Off-time shows the inverse, so a phase bit of one flips the duty
            if (!pwm_run || code == `INTENSITY_STATIC) begin
                next_oe_n[k] = level;
            end else if (slot < master && cycle <= code) begin
                next_oe_n[k] = level;
            end else begin
                next_oe_n[k] = ~level;
            end
        end
    end

    // Registered pin enables, low drives the pin low
    // The register keeps decode glitches off ports held static
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            port_oe_n <= `RST_OE_N;
        end else begin
            port_oe_n <= next_oe_n;
        end
    end

endmodule
`default_nettype wire

// ===== led_pwm_chk_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module led_pwm_chk (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register access
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // Phase levels and pins
    input wire logic [16:0] phase0_bits,
    input wire logic [16:0] phase1_bits,
    input wire logic blink_enable,
    input wire logic blink_phase,
    input wire logic [16:0] port_oe_n,
    input wire logic osc_running
);
    logic [7:0] mg;
    wire logic [16:0] lvl = (blink_enable && blink_phase) ? phase1_bits : phase0_bits;
    // Shadow of the master and global register
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) mg <= 8'h00;
        else if (reg_wr && reg_addr == 8'h0E) mg <= reg_wdata;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_mst_on;
        reg_wr && reg_addr == 8'h0E && reg_wdata[7:4] != 4'h0;
    endsequence
    sequence s_mst_off;
        reg_wr && reg_addr == 8'h0E && reg_wdata[7:4] == 4'h0;
    endsequence
    chk_osc_follow: assert property (osc_running == (mg[7:4] != 4'h0))
        else $error("oscillator state differs from master nibble");
    chk_master_start: assert property (s_mst_on |=> osc_running)
        else $error("oscillator not started");
    chk_master_stop: assert property (s_mst_off |=> !osc_running)
        else $error("oscillator not stopped");
    chk_static_level: assert property (!osc_running |=> port_oe_n == $past(lvl))
        else $error("static level wrong");
    chk_full_static: assert property (mg[3:0] == 4'hF |=> port_oe_n[16] == $past(lvl[16]))
        else $error("full setting not static");
    chk_first_on: assert property ($rose(osc_running) && mg[3:0] != 4'hF |-> ##[1:3] port_oe_n[16] == lvl[16])
        else $error("first step not on");
    chk_mg_readback: assert property (reg_rd && reg_addr == 8'h0E |=> reg_rdata == $past(mg))
        else $error("master register readback wrong");
    chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved");
endmodule
bind led_pwm_intensity_engine led_pwm_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .phase0_bits(phase0_bits), .phase1_bits(phase1_bits),
    .blink_enable(blink_enable), .blink_phase(blink_phase), .port_oe_n(port_oe_n),
    .osc_running(osc_running));
`default_nettype wire

// ===== led_load.sv
`timescale 1ns/10ps
`default_nettype none
module led_load (
    // Pin drive from the block
    input wire logic [16:0] port_oe_n,
    input wire logic [16:0] port_out,
    // Resulting pin level
    output wire logic [16:0] pin
);
    // Pull-up loads: a released pin floats high
    assign pin = port_oe_n | port_out;
endmodule
`default_nettype wire

// ===== test_led_pwm_intensity_engine.sv
`timescale 1ns/10ps
`default_nettype none
module test_led_pwm_intensity_engine;
    logic clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, blink_enable = 0, blink_phase = 0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
    logic [16:0] phase0_bits = 17'h00004, phase1_bits = 17'h1FFFB;
    logic [31:0] n0, n1, n2, n16;
    wire logic [7:0] reg_rdata;
    wire logic [16:0] port_out, port_oe_n, pin;
    wire logic osc_running;
    int bad_count = 0, n_compared = 0;
    led_pwm_intensity_engine uut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .phase0_bits(phase0_bits), .phase1_bits(phase1_bits), .blink_enable(blink_enable),
        .blink_phase(blink_phase), .port_in(pin), .port_out(port_out),
        .port_oe_n(port_oe_n), .osc_running(osc_running));
    led_load u_load (.port_oe_n(port_oe_n), .port_out(port_out), .pin(pin));
    // Clock
    initial forever #20 clk_sys = ~clk_sys;
    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task test_done;
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    function automatic logic [31:0] near(input logic [31:0] s, input logic [31:0] e);
        near = (s + 2 >= e && s <= e + 2) ? e : s;
    endfunction
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_wr = 1; reg_addr = a; reg_wdata = d;
        @(negedge clk_sys);
        reg_wr = 0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_sys);
        reg_rd = 1; reg_addr = a;
        @(negedge clk_sys);
        reg_rd = 0;
        check("reg_rdata", reg_rdata, e);
    endtask
    // Count low pin cycles over three timeslots from a fresh timebase start
    task meas;
        n0 = 0; n1 = 0; n2 = 0; n16 = 0;
        repeat (37488) begin
            @(negedge clk_sys);
            n0 += !pin[0]; n1 += !pin[1]; n2 += !pin[2]; n16 += !pin[16];
        end
    endtask
    task t_regs;
        rd(8'h0E, 8'h00);
        rd(8'h10, 8'hFF);
        rd(8'h17, 8'hFF);
        rd(8'h30, 8'h00);
        wr(8'h17, 8'hA5);
        rd(8'h17, 8'hA5);
        wr(8'h17, 8'hFF);
        rd(8'h0F, 8'h00);
        wr(8'h00, 8'hFF);
        rd(8'h00, 8'h04);
        rd(8'h01, 8'h00);
        rd(8'h20, 8'h00);
        check("port_out", port_out, 17'h00000);
    endtask
    // Reset in mid-run: registers and pins go back to their reset state
    task t_reset;
        @(negedge clk_sys);
        rst_n = 0;
        @(negedge clk_sys);
        check("oe_in_reset", port_oe_n, 17'h1FFFF);
        check("osc_in_reset", osc_running, 1'b0);
        check("rdata_in_reset", reg_rdata, 8'h00);
        rst_n = 1;
        rd(8'h0E, 8'h00);
        rd(8'h0F, 8'h00);
        rd(8'h10, 8'hFF);
        check("oe_after_reset", port_oe_n, phase0_bits);
    endtask
    task t_static;
        wr(8'h0E, 8'h0F);
        repeat (2) @(negedge clk_sys);
        check("oe_static", port_oe_n, phase0_bits);
        check("osc_off", osc_running, 1'b0);
        blink_enable = 1; blink_phase = 1;
        repeat (2) @(negedge clk_sys);
        check("oe_phase1", port_oe_n, phase1_bits);
        blink_phase = 0;
        repeat (2) @(negedge clk_sys);
        check("oe_phase0", port_oe_n, phase0_bits);
        blink_enable = 0;
    endtask
    task t_pwm_own;
        wr(8'h10, 8'hF2);
        wr(8'h0E, 8'h23);
        meas;
        check("osc_on", osc_running, 1'b1);
        check("low_p0", near(n0, 4686), 4686);
        check("low_p1", n1, 37488);
        check("low_p2", n2, 0);
        check("low_p16", near(n16, 6248), 6248);
    endtask
    task t_pwm_glob;
        wr(8'h0E, 8'h00);
        wr(8'h0F, 8'h04);
        wr(8'h0E, 8'h23);
        meas;
        check("glob_p0", near(n0, 6248), 6248);
        check("glob_p1", near(n1, 6248), 6248);
        check("glob_p2", near(n2, 31240), 31240);
        check("glob_p16", near(n16, 6248), 6248);
    endtask
    // Main sequence
    initial begin
        repeat (20) @(negedge clk_sys);
        check("oe_reset", port_oe_n, 17'h1FFFF);
        rst_n = 1;
        t_regs;
        t_static;
        t_pwm_own;
        t_pwm_glob;
        t_reset;
        test_done;
    end
    // Watchdog
    initial begin
        repeat (95000) @(posedge clk_sys);
        bad_count++;
        test_done;
    end
endmodule
`default_nettype wire
